// ==== src/sesf_pkg.sv ====
// shared constants for the status word execution-state block
package sesf_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0]  ADDR_COMBINED   = 8'h00;
	localparam logic [7:0]  ADDR_EXEC_VIEW  = 8'h04;
	localparam logic [7:0]  ADDR_INTR_VIEW  = 8'h08;
	localparam logic [7:0]  ADDR_CTRL       = 8'h0c;
	localparam logic [7:0]  ADDR_STAT       = 8'h10;
	// ---------------------------------------------------------------
	// field positions of the status word
	// ---------------------------------------------------------------
	localparam int          POS_ISA_STATE   = 24;
	localparam int          POS_COND_HI_LSB = 25;
	localparam int          POS_COND_LO_LSB = 10;
	localparam int          POS_RESUME_LSB  = 12;
	localparam int          EXC_W           = 6;
	localparam int          COND_W          = 8;
	localparam logic [31:0] MASK_EXEC_VIEW  = 32'h0700_fc00;
	localparam logic [31:0] MASK_INTR_VIEW  = 32'h0000_003f;
	localparam logic [31:0] MASK_RESERVED   = 32'h00ff_03c0;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic        RST_ISA_STATE   = 1'b1;
	localparam logic [7:0]  RST_COND        = 8'h00;
	localparam logic [5:0]  RST_EXC_NUM     = 6'h00;
	// ---------------------------------------------------------------
	// control and status bits
	// ---------------------------------------------------------------
	localparam int          CTRL_LOCKUP_SEL = 0;
	localparam int          STAT_BAD_EXC    = 0;
	localparam int          STAT_LOCKUP     = 1;
	localparam int          STAT_RESUME     = 2;
	// ---------------------------------------------------------------
	// active exception numbers
	// ---------------------------------------------------------------
	localparam logic [5:0]  EXC_THREAD      = 6'h00;
	localparam logic [5:0]  EXC_NMI         = 6'h02;
	localparam logic [5:0]  EXC_HARD_FAULT  = 6'h03;
	localparam logic [5:0]  EXC_MEM_FAULT   = 6'h04;
	localparam logic [5:0]  EXC_BUS_FAULT   = 6'h05;
	localparam logic [5:0]  EXC_USAGE_FAULT = 6'h06;
	localparam logic [5:0]  EXC_SUPV_CALL   = 6'h0b;
	localparam logic [5:0]  EXC_PEND_SVC    = 6'h0e;
	localparam logic [5:0]  EXC_SYS_TICK    = 6'h0f;
	localparam logic [5:0]  EXC_IRQ_FIRST   = 6'h10;
	localparam logic [5:0]  EXC_IRQ_LAST    = 6'h3b;
	// ---------------------------------------------------------------
	// bus responses
	// ---------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

// ==== src/sesf_reg_if.sv ====
// register access carrier between bus slave and register file
interface sesf_reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_err;
	logic        rd_en;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_err;
	modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_err, rd_data, rd_err);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_err, rd_data, rd_err);
endinterface

// ==== src/sesf_axil_slave.sv ====
// axi4-lite slave front end
module sesf_axil_slave
	import sesf_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  awaddr_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	output logic [1:0]       bresp_o,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	input  wire logic [7:0]  araddr_i,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	sesf_reg_if.bus          reg_port
);
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;

	assign awready_o = !aw_held && !bvalid_o;
	assign wready_o  = !w_held && !bvalid_o;
	assign arready_o = !rvalid_o;
	assign do_write  = aw_held && w_held && !bvalid_o;

	assign reg_port.wr_en   = do_write;
	assign reg_port.wr_addr = aw_addr;
	assign reg_port.wr_data = w_data;
	assign reg_port.wr_strb = w_strb;
	assign reg_port.rd_en   = arvalid_i && arready_o;
	assign reg_port.rd_addr = araddr_i;

	// ---------------------------------------------------------------
	// write channels, taken in either order
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (awvalid_i && awready_o) begin
			aw_held <= 1'b1;
			aw_addr <= awaddr_i;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (wvalid_i && wready_o) begin
			w_held <= 1'b1;
			w_data <= wdata_i;
			w_strb <= wstrb_i;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bvalid_o <= 1'b0;
			bresp_o  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_o <= 1'b1;
			bresp_o  <= reg_port.wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (bready_i) begin
			bvalid_o <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// read channel, one cycle to data
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_o <= 1'b0;
			rdata_o  <= 32'h0000_0000;
			rresp_o  <= RESP_OKAY;
		end else if (reg_port.rd_en) begin
			rvalid_o <= 1'b1;
			rdata_o  <= reg_port.rd_data;
			rresp_o  <= reg_port.rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rready_i) begin
			rvalid_o <= 1'b0;
		end
	end
endmodule

// ==== src/sesf_top.sv ====
// status word execution-state fields with register access
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
module sesf_top
	import sesf_pkg::*;
(
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_N_I,
	input  wire logic [7:0]  S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	input  wire logic [7:0]  S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	input  wire logic        EXC_ENTRY_I,
	input  wire logic [5:0]  EXC_NUM_I,
	input  wire logic        VEC_BIT0_I,
	input  wire logic        EXC_RETURN_I,
	input  wire logic [31:0] STACKED_STATUS_WORD_I,
	input  wire logic        BRANCH_EXCHANGE_I,
	input  wire logic        BRANCH_TARGET_BIT0_I,
	input  wire logic        MT_SUSPEND_I,
	input  wire logic [3:0]  MT_NEXT_REG_I,
	input  wire logic        MT_RESUME_ACK_I,
	input  wire logic        COND_BLOCK_START_I,
	input  wire logic [7:0]  COND_BLOCK_STATE_I,
	input  wire logic        COND_BLOCK_ADVANCE_I,
	input  wire logic        EXEC_REQ_I,
	output logic             EXEC_GRANT_O,
	output logic             EXEC_FAULT_O,
	output logic             LOCKUP_O,
	output logic [31:0]      STACKED_STATUS_WORD_O,
	output logic             MT_RESUME_VALID_O,
	output logic [3:0]       MT_RESUME_REG_O,
	output logic             COND_ACTIVE_O,
	output logic [3:0]       COND_CODE_O
);
	sesf_reg_if reg_port ();

	logic        isa_state;
	logic [7:0]  cond_block_state;
	logic        held_xfer;
	logic [5:0]  active_exception_number;
	logic        lockup_sel;
	logic        bad_exc;
	logic [31:0] program_status_word;
	logic        exc_ok;
	logic        ret_held;
	logic        bad_try;

	sesf_axil_slave u_slave (
		.clk_i     (CLK_SYS_I),
		.rst_n_i   (RST_N_I),
		.awaddr_i  (S_AXI_AWADDR_I),
		.awvalid_i (S_AXI_AWVALID_I),
		.awready_o (S_AXI_AWREADY_O),
		.wdata_i   (S_AXI_WDATA_I),
		.wstrb_i   (S_AXI_WSTRB_I),
		.wvalid_i  (S_AXI_WVALID_I),
		.wready_o  (S_AXI_WREADY_O),
		.bresp_o   (S_AXI_BRESP_O),
		.bvalid_o  (S_AXI_BVALID_O),
		.bready_i  (S_AXI_BREADY_I),
		.araddr_i  (S_AXI_ARADDR_I),
		.arvalid_i (S_AXI_ARVALID_I),
		.arready_o (S_AXI_ARREADY_O),
		.rdata_o   (S_AXI_RDATA_O),
		.rresp_o   (S_AXI_RRESP_O),
		.rvalid_o  (S_AXI_RVALID_O),
		.rready_i  (S_AXI_RREADY_I),
		.reg_port  (reg_port)
	);

	// ---------------------------------------------------------------
	// combined word assembly
	// ---------------------------------------------------------------
	always_comb begin
		program_status_word = 32'h0000_0000;
		program_status_word[POS_ISA_STATE] = isa_state;
		program_status_word[POS_COND_HI_LSB +: 2] = cond_block_state[1:0];
		program_status_word[POS_COND_LO_LSB +: 6] = cond_block_state[7:2];
		program_status_word[EXC_W-1:0] = active_exception_number;
	end

	// reserved numbers: 0x01, 0x07-0x0a, 0x0c, 0x0d, above 0x3b
	always_comb begin
		exc_ok = 1'b1;
		if (EXC_NUM_I == 6'h01) begin
			exc_ok = 1'b0;
		end else if (EXC_NUM_I > EXC_USAGE_FAULT && EXC_NUM_I < EXC_SUPV_CALL) begin
			exc_ok = 1'b0;
		end else if (EXC_NUM_I > EXC_SUPV_CALL && EXC_NUM_I < EXC_PEND_SVC) begin
			exc_ok = 1'b0;
		end else if (EXC_NUM_I > EXC_IRQ_LAST) begin
			exc_ok = 1'b0;
		end
	end

	// restored word carries a continuable transfer when 26:25, 11:10 are zero and 15:12 is nonzero
	assign ret_held = STACKED_STATUS_WORD_I[POS_COND_HI_LSB +: 2] == 2'b00
		&& STACKED_STATUS_WORD_I[POS_COND_LO_LSB +: 2] == 2'b00
		&& STACKED_STATUS_WORD_I[POS_RESUME_LSB +: 4] != 4'h0;

	// entry stacks the live word, folding in a suspension of the same cycle
	always_comb begin
		STACKED_STATUS_WORD_O = program_status_word;
		if (MT_SUSPEND_I) begin
			STACKED_STATUS_WORD_O[POS_COND_HI_LSB +: 2] = 2'b00;
			STACKED_STATUS_WORD_O[POS_COND_LO_LSB +: 6] = {MT_NEXT_REG_I, 2'b00};
		end
	end

	// ---------------------------------------------------------------
	// instruction-set state bit
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			isa_state <= RST_ISA_STATE;
		end else if (EXC_ENTRY_I && exc_ok) begin
			isa_state <= VEC_BIT0_I;
		end else if (EXC_RETURN_I) begin
			isa_state <= STACKED_STATUS_WORD_I[POS_ISA_STATE];
		end else if (BRANCH_EXCHANGE_I) begin
			isa_state <= BRANCH_TARGET_BIT0_I;
		end
	end

	// ---------------------------------------------------------------
	// continuable transfer and block state
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cond_block_state <= RST_COND;
			held_xfer        <= 1'b0;
		end else if (EXC_ENTRY_I && exc_ok) begin
			cond_block_state <= RST_COND;
			held_xfer        <= 1'b0;
		end else if (EXC_RETURN_I) begin
			cond_block_state <= {STACKED_STATUS_WORD_I[POS_COND_LO_LSB +: 6],
				STACKED_STATUS_WORD_I[POS_COND_HI_LSB +: 2]};
			held_xfer        <= ret_held;
		// record next operand, low bits zero
		end else if (MT_SUSPEND_I) begin
			cond_block_state <= {MT_NEXT_REG_I, 4'h0};
			held_xfer        <= 1'b1;
		end else if (MT_RESUME_ACK_I && held_xfer) begin
			cond_block_state <= RST_COND;
			held_xfer        <= 1'b0;
		end else if (COND_BLOCK_START_I) begin
			cond_block_state <= COND_BLOCK_STATE_I;
			held_xfer        <= 1'b0;
		end else if (COND_BLOCK_ADVANCE_I && !held_xfer) begin
			if (cond_block_state[2:0] == 3'b000) begin
				cond_block_state <= RST_COND;
			end else begin
				cond_block_state[4:0] <= {cond_block_state[3:0], 1'b0};
			end
		end
	end

	assign COND_ACTIVE_O = !held_xfer && cond_block_state[3:0] != 4'h0;
	assign COND_CODE_O   = cond_block_state[7:4];
	assign MT_RESUME_VALID_O = held_xfer;
	assign MT_RESUME_REG_O   = cond_block_state[7:4];

	// ---------------------------------------------------------------
	// active exception number
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			active_exception_number <= RST_EXC_NUM;
		end else if (EXC_ENTRY_I && exc_ok) begin
			active_exception_number <= EXC_NUM_I;
		end else if (EXC_RETURN_I) begin
			active_exception_number <= STACKED_STATUS_WORD_I[EXC_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// execution gate, fault and lockup
	// ---------------------------------------------------------------
	assign bad_try = EXEC_REQ_I && !isa_state && !LOCKUP_O;
	// no execution with the state bit clear
	assign EXEC_GRANT_O = EXEC_REQ_I && isa_state && !LOCKUP_O;

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			EXEC_FAULT_O <= 1'b0;
			LOCKUP_O     <= 1'b0;
		end else begin
			// fault, or lockup when selected or already in hard fault or NMI
			EXEC_FAULT_O <= bad_try && !lockup_sel
				&& active_exception_number != EXC_HARD_FAULT
				&& active_exception_number != EXC_NMI;
			if (bad_try && (lockup_sel || active_exception_number == EXC_HARD_FAULT
				|| active_exception_number == EXC_NMI)) begin
				LOCKUP_O <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			lockup_sel <= 1'b0;
		end else if (reg_port.wr_en && reg_port.wr_addr == ADDR_CTRL
			&& reg_port.wr_strb[0]) begin
			lockup_sel <= reg_port.wr_data[CTRL_LOCKUP_SEL];
		end
	end

	// set wins over the write-one clear
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			bad_exc <= 1'b0;
		end else if (EXC_ENTRY_I && !exc_ok) begin
			bad_exc <= 1'b1;
		end else if (reg_port.wr_en && reg_port.wr_addr == ADDR_STAT
			&& reg_port.wr_strb[0] && reg_port.wr_data[STAT_BAD_EXC]) begin
			bad_exc <= 1'b0;
		end
	end

	// status word views accept writes and change nothing
	always_comb begin
		reg_port.wr_err = 1'b0;
		if (reg_port.wr_addr[1:0] != 2'b00) begin
			reg_port.wr_err = 1'b1;
		end else if (reg_port.wr_addr > ADDR_STAT) begin
			reg_port.wr_err = 1'b1;
		end
	end

	// views mask the fields they do not carry
	always_comb begin
		reg_port.rd_data = 32'h0000_0000;
		reg_port.rd_err  = 1'b0;
		if (reg_port.rd_addr == ADDR_COMBINED) begin
			reg_port.rd_data = program_status_word & ~MASK_RESERVED;
		end else if (reg_port.rd_addr == ADDR_EXEC_VIEW) begin
			reg_port.rd_data = program_status_word & MASK_EXEC_VIEW;
		end else if (reg_port.rd_addr == ADDR_INTR_VIEW) begin
			reg_port.rd_data = program_status_word & MASK_INTR_VIEW;
		end else if (reg_port.rd_addr == ADDR_CTRL) begin
			reg_port.rd_data[CTRL_LOCKUP_SEL] = lockup_sel;
		end else if (reg_port.rd_addr == ADDR_STAT) begin
			reg_port.rd_data[STAT_BAD_EXC] = bad_exc;
			reg_port.rd_data[STAT_LOCKUP]  = LOCKUP_O;
			reg_port.rd_data[STAT_RESUME]  = held_xfer;
		end else begin
			reg_port.rd_err = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);

	AST_ENTRY_VEC_BIT: assert property (EXC_ENTRY_I && exc_ok |=>
		isa_state == $past(VEC_BIT0_I)) else $error("state bit not taken from vector");
	AST_BRANCH_CLEAR: assert property (BRANCH_EXCHANGE_I && !BRANCH_TARGET_BIT0_I
		&& !EXC_ENTRY_I && !EXC_RETURN_I |=> !isa_state) else $error("branch did not clear");
	AST_NO_EXEC_CLEAR: assert property (EXEC_REQ_I && !isa_state |-> !EXEC_GRANT_O
		##1 (EXEC_FAULT_O || LOCKUP_O)) else $error("execution with state bit clear");
	AST_RESERVED_ZERO: assert property (reg_port.rd_en |=>
		(S_AXI_RDATA_O & MASK_RESERVED) == 32'h0) else $error("reserved bits not zero");
	AST_BLOCK_LOAD: assert property (COND_BLOCK_START_I && !EXC_ENTRY_I && !EXC_RETURN_I
		&& !MT_SUSPEND_I && !(MT_RESUME_ACK_I && held_xfer) |=>
		program_status_word[26:25] == $past(COND_BLOCK_STATE_I[1:0])
		&& program_status_word[15:10] == $past(COND_BLOCK_STATE_I[7:2]))
		else $error("block state not placed in word");
	AST_SUSPEND_REG: assert property (MT_SUSPEND_I && !EXC_ENTRY_I && !EXC_RETURN_I |=>
		program_status_word[15:12] == $past(MT_NEXT_REG_I)) else $error("operand not recorded");
	AST_RESUME_AT_REG: assert property (EXC_RETURN_I && !EXC_ENTRY_I && ret_held |=>
		MT_RESUME_VALID_O && MT_RESUME_REG_O == $past(STACKED_STATUS_WORD_I[15:12]))
		else $error("resume point lost");
	AST_HELD_LOW_ZERO: assert property (held_xfer |->
		program_status_word[11:10] == 2'b00 && program_status_word[26:25] == 2'b00)
		else $error("low bits set while transfer held");
	AST_BLOCK_END: assert property (COND_BLOCK_ADVANCE_I && COND_ACTIVE_O
		&& cond_block_state[2:0] == 3'b000 && !EXC_ENTRY_I && !EXC_RETURN_I
		&& !MT_SUSPEND_I && !COND_BLOCK_START_I |=> !COND_ACTIVE_O)
		else $error("block did not end");
	AST_EXC_NUMBER: assert property (EXC_ENTRY_I && exc_ok |=>
		active_exception_number == $past(EXC_NUM_I) && active_exception_number <= EXC_IRQ_LAST)
		else $error("wrong exception number");
	AST_INTR_VIEW: assert property (reg_port.rd_en && reg_port.rd_addr == ADDR_INTR_VIEW
		|=> S_AXI_RDATA_O[31:6] == 26'h0 && S_AXI_RDATA_O[5:0] == $past(active_exception_number))
		else $error("interrupt view shows state fields");

	COV_BAD_STATE_FAULT: cover property (EXEC_REQ_I && !isa_state ##1 EXEC_FAULT_O);
	COV_SUSPEND_RESUME: cover property (MT_SUSPEND_I ##[1:20] EXC_RETURN_I && ret_held);
	COV_FOUR_BLOCK: cover property (COND_BLOCK_START_I ##1 COND_ACTIVE_O [*4] ##1 !COND_ACTIVE_O);
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the status word execution-state block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sesf_pkg::*;
	// ----
	// signals and model
	// ----
	logic        CLK_SYS_I = 0, RST_N_I = 0, EXEC_REQ_I = 0;
	logic [7:0]  S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0, COND_BLOCK_STATE_I = '0;
	logic [31:0] S_AXI_WDATA_I = '0, STACKED_STATUS_WORD_I = '0;
	logic [3:0]  S_AXI_WSTRB_I = 4'hf, MT_NEXT_REG_I = '0;
	logic [5:0]  EXC_NUM_I = '0;
	logic        S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
	logic        S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0, EXC_ENTRY_I = 0, VEC_BIT0_I = 0;
	logic        EXC_RETURN_I = 0, BRANCH_EXCHANGE_I = 0, BRANCH_TARGET_BIT0_I = 0;
	logic        MT_SUSPEND_I = 0, MT_RESUME_ACK_I = 0, COND_BLOCK_START_I = 0;
	logic        COND_BLOCK_ADVANCE_I = 0;
	logic        S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
	logic        S_AXI_RVALID_O, EXEC_GRANT_O, EXEC_FAULT_O, LOCKUP_O;
	logic        MT_RESUME_VALID_O, COND_ACTIVE_O;
	logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O, rs;
	logic [31:0] S_AXI_RDATA_O, STACKED_STATUS_WORD_O, rd;
	logic [3:0]  MT_RESUME_REG_O, COND_CODE_O, mr;
	logic [15:0] lf = 16'h77c0;
	logic [7:0]  cs;
	logic [5:0]  num;
	logic        isa, mv;
	logic [5:0]  codes [11] = '{EXC_THREAD, EXC_NMI, EXC_HARD_FAULT, EXC_MEM_FAULT,
		EXC_BUS_FAULT, EXC_USAGE_FAULT, EXC_SUPV_CALL, EXC_PEND_SVC, EXC_SYS_TICK,
		EXC_IRQ_FIRST, EXC_IRQ_LAST};
	logic [5:0]  bad [4] = '{6'h01, 6'h0a, 6'h0c, 6'h3c};
	int          error_cnt = 0, compares = 0;
	sesf_top DUT (.*);
	always #2.5 CLK_SYS_I = ~CLK_SYS_I;
	// ----
	// helpers
	// ----
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction
	function automatic logic [31:0] word();
		return {5'h00, cs[1:0], isa, 8'h00, mv ? {mr, 2'b00} : cs[7:2], 4'h0, num};
	endfunction
	task automatic final_report();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		logic aw, w, b;
		@(posedge CLK_SYS_I);
		S_AXI_AWADDR_I <= a;
		S_AXI_WDATA_I <= d;
		S_AXI_AWVALID_I <= 1;
		S_AXI_WVALID_I <= 1;
		S_AXI_BREADY_I <= 1;
		for (int i = 0; i <= 100; i++) begin
			if (i == 100) begin
				error_cnt++;
				final_report();
			end
			@(negedge CLK_SYS_I);
			aw = S_AXI_AWREADY_O;
			w = S_AXI_WREADY_O;
			b = S_AXI_BVALID_O;
			rs = S_AXI_BRESP_O;
			@(posedge CLK_SYS_I);
			if (aw) S_AXI_AWVALID_I <= 0;
			if (w) S_AXI_WVALID_I <= 0;
			if (b) break;
		end
		S_AXI_BREADY_I <= 0;
		cmp("bresp", er, rs);
	endtask
	task automatic axr(logic [7:0] a);
		logic ar, r;
		@(posedge CLK_SYS_I);
		S_AXI_ARADDR_I <= a;
		S_AXI_ARVALID_I <= 1;
		S_AXI_RREADY_I <= 1;
		for (int i = 0; i <= 100; i++) begin
			if (i == 100) begin
				error_cnt++;
				final_report();
			end
			@(negedge CLK_SYS_I);
			ar = S_AXI_ARREADY_O;
			r = S_AXI_RVALID_O;
			rd = S_AXI_RDATA_O;
			rs = S_AXI_RRESP_O;
			@(posedge CLK_SYS_I);
			if (ar) S_AXI_ARVALID_I <= 0;
			if (r) break;
		end
		S_AXI_RREADY_I <= 0;
	endtask
	task automatic views();
		logic [31:0] e;
		e = word();
		axr(ADDR_COMBINED);
		cmp("combined", e, rd);
		axr(ADDR_EXEC_VIEW);
		cmp("exec_view", e & MASK_EXEC_VIEW, rd);
		axr(ADDR_INTR_VIEW);
		cmp("intr_view", e & MASK_INTR_VIEW, rd);
		@(negedge CLK_SYS_I);
		cmp("stack_word", e, STACKED_STATUS_WORD_O);
	endtask
	task automatic tick();
		@(posedge CLK_SYS_I);
		EXC_ENTRY_I <= 0;
		EXC_RETURN_I <= 0;
		BRANCH_EXCHANGE_I <= 0;
		MT_SUSPEND_I <= 0;
		MT_RESUME_ACK_I <= 0;
		COND_BLOCK_START_I <= 0;
		COND_BLOCK_ADVANCE_I <= 0;
		EXEC_REQ_I <= 0;
		@(negedge CLK_SYS_I);
	endtask
	task automatic enter(logic [5:0] n, logic v);
		@(posedge CLK_SYS_I);
		EXC_ENTRY_I <= 1;
		EXC_NUM_I <= n;
		VEC_BIT0_I <= v;
		tick();
	endtask
	task automatic try_exec(logic g, logic f, logic l);
		@(posedge CLK_SYS_I);
		EXEC_REQ_I <= 1;
		@(negedge CLK_SYS_I);
		cmp("grant", g, EXEC_GRANT_O);
		tick();
		cmp("fault", f, EXEC_FAULT_O);
		cmp("lockup", l, LOCKUP_O);
	endtask
	task automatic branch(logic b);
		@(posedge CLK_SYS_I);
		BRANCH_EXCHANGE_I <= 1;
		BRANCH_TARGET_BIT0_I <= b;
		tick();
		isa = b;
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		logic [7:0] s;
		repeat (4) @(posedge CLK_SYS_I);
		RST_N_I <= 1;
		{isa, num, cs, mr, mv} = {1'b1, 19'h0};
		views();
		foreach (codes[i]) begin
			enter(codes[i], 1);
			num = codes[i];
			views();
		end
		num = EXC_IRQ_FIRST + 6'(rnd() % 44);
		enter(num, 1);
		foreach (bad[i]) begin
			enter(bad[i], 1);
			axr(ADDR_STAT);
			cmp("bad_exc", 32'h1, rd & 32'h7);
			axw(ADDR_STAT, 32'h1, RESP_OKAY);
		end
		views();
		axw(ADDR_COMBINED, ~word() & ~MASK_RESERVED, RESP_OKAY);
		axw(ADDR_EXEC_VIEW, ~word() & ~MASK_RESERVED, RESP_OKAY);
		views();
		axw(8'h14, 32'h1, RESP_SLVERR);
		axw(8'h02, 32'h1, RESP_SLVERR);
		axr(8'h14);
		cmp("rresp_unmapped", {30'h0, RESP_SLVERR}, {rd[29:0], rs});
		try_exec(1, 0, 0);
		enter(EXC_IRQ_FIRST, 0);
		{isa, num} = {1'b0, EXC_IRQ_FIRST};
		views();
		try_exec(0, 1, 0);
		branch(1);
		views();
		@(posedge CLK_SYS_I);
		EXC_RETURN_I <= 1;
		STACKED_STATUS_WORD_I <= 32'h0000_5000 | 32'(EXC_SYS_TICK);
		tick();
		{isa, num, mv, mr} = {1'b0, EXC_SYS_TICK, 1'b1, 4'h5};
		cmp("resume_reg", {1'b1, 4'h5}, {MT_RESUME_VALID_O, MT_RESUME_REG_O});
		views();
		@(posedge CLK_SYS_I);
		MT_RESUME_ACK_I <= 1;
		tick();
		mv = 0;
		branch(1);
		mr = 4'(rnd() % 15 + 1);
		@(posedge CLK_SYS_I);
		MT_SUSPEND_I <= 1;
		MT_NEXT_REG_I <= mr;
		mv = 1;
		@(negedge CLK_SYS_I);
		cmp("stack_suspend", word(), STACKED_STATUS_WORD_O);
		tick();
		cmp("resume_reg", {1'b1, mr}, {MT_RESUME_VALID_O, MT_RESUME_REG_O});
		views();
		axr(ADDR_STAT);
		cmp("stat_resume", 32'h4, rd);
		enter(EXC_SYS_TICK, 1);
		{mv, num} = {1'b0, EXC_SYS_TICK};
		for (int k = 0; k < 4; k++) begin
			s = 8'(rnd());
			if (k == 0) s[3:0] = 4'h1;
			if (s[3:0] == 4'h0) s[3:0] = 4'h8;
			@(posedge CLK_SYS_I);
			COND_BLOCK_START_I <= 1;
			COND_BLOCK_STATE_I <= s;
			tick();
			cs = s;
			for (int j = 0; j < 5; j++) begin
				cmp("cond", {cs[3:0] != 4'h0, cs[7:4]}, {COND_ACTIVE_O, COND_CODE_O});
				views();
				@(posedge CLK_SYS_I);
				COND_BLOCK_ADVANCE_I <= 1;
				tick();
				cs = (cs[2:0] == 3'h0) ? 8'h00 : {cs[7:5], cs[3:0], 1'b0};
			end
		end
		axw(ADDR_CTRL, 32'h1, RESP_OKAY);
		axr(ADDR_CTRL);
		cmp("ctrl", 32'h1, rd);
		branch(0);
		try_exec(0, 0, 1);
		axr(ADDR_STAT);
		cmp("stat_lockup", 32'h2, rd & 32'h2);
		@(posedge CLK_SYS_I);
		RST_N_I <= 0;
		repeat (4) @(posedge CLK_SYS_I);
		RST_N_I <= 1;
		{isa, num, cs, mr, mv} = {1'b1, 19'h0};
		views();
		cmp("lockup_rst", 0, LOCKUP_O);
		enter(EXC_HARD_FAULT, 0);
		try_exec(0, 0, 1);
		final_report();
	end
endmodule
